// ==== logic/flash_host.sv ====
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_host (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // flash pins
    output logic [17:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic             flash_reset_n,
    input  wire logic        ready_busy_out
);
    localparam logic [9:0] RP_CYC    = 10'(`RESET_PULSE_MIN_CYC);
    localparam logic [9:0] RH_CYC    = 10'(`RESET_HIGH_CYC);
    localparam logic [9:0] ABORT_CYC = 10'(`ABORT_RECOVERY_CYC);
    localparam logic [9:0] BUSY_CYC  = 10'(`BUSY_DELAY_CYC);

    flash_cyc_if cyc ();

    flash_host_pkg::seq_state_t state_reg;
    flash_host_pkg::seq_state_t state_next;
    logic [5:0]  cmd_reg;
    logic [5:0]  cmd_next;
    logic [17:0] addr_reg;
    logic [17:0] addr_next;
    logic [15:0] wdata_reg;
    logic [15:0] wdata_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [9:0]  cnt_reg;
    logic [9:0]  cnt_next;
    logic        done_reg;
    logic        done_next;
    logic        abort_reg;
    logic        abort_next;
    logic        first_reg;
    logic        first_next;
    logic        rst_n_reg;
    logic        rst_n_next;
    logic [31:0] prdata_next;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    logic        finish;
    flash_host_pkg::op_t op;

    // ======================================================================
    // apb decode
    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite;
    assign mapped = (paddr == `OFS_CMD) || (paddr == `OFS_ADDR) ||
                    (paddr == `OFS_WDATA) || (paddr == `OFS_RDATA) ||
                    (paddr == `OFS_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign op = flash_host_pkg::op_t'(cmd_reg[`CMD_OP_MSB:`CMD_OP_LSB]);

    always_comb
    begin
        prdata_next = prdata;
        if (setup)
        begin
            prdata_next = 32'h00000000;
            unique case (paddr)
                `OFS_CMD:    prdata_next[5:0]  = cmd_reg;
                `OFS_ADDR:   prdata_next[17:0] = addr_reg;
                `OFS_WDATA:  prdata_next[15:0] = wdata_reg;
                `OFS_RDATA:  prdata_next[15:0] = rdata_reg;
                `OFS_STATUS:
                begin
                    prdata_next[`STS_ACTIVE_BIT] =
                        (state_reg != flash_host_pkg::S_IDLE);
                    prdata_next[`STS_READY_BIT] = ready_busy_out;
                    prdata_next[`STS_DONE_BIT] = done_reg;
                end
                default:     prdata_next = 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // bus cycle requests
    assign cyc.req = (state_reg == flash_host_pkg::S_CYC) ||
                     (state_reg == flash_host_pkg::S_POLL_RD);
    assign cyc.write = (state_reg == flash_host_pkg::S_CYC) &&
                       (op == flash_host_pkg::OP_WRITE);
    assign cyc.ce_strobe  = cmd_reg[`CMD_CE_BIT];
    assign cyc.long_pulse = cmd_reg[`CMD_PROT_BIT];
    assign cyc.addr  = addr_reg;
    assign cyc.wdata = wdata_reg;

    // ======================================================================
    // sequencer
    always_comb
    begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        cnt_next   = cnt_reg + 10'h001;
        abort_next = abort_reg;
        first_next = first_reg;
        rst_n_next = rst_n_reg;
        finish     = 1'b0;
        unique case (state_reg)
            flash_host_pkg::S_IDLE:
            begin
                cnt_next = 10'h000;
                if (wr_en && paddr == `OFS_ADDR)
                    addr_next = pwdata[17:0];
                if (wr_en && paddr == `OFS_WDATA)
                    wdata_next = pwdata[15:0];
                if (wr_en && paddr == `OFS_CMD)
                begin
                    cmd_next = pwdata[5:0];
                    unique case (pwdata[`CMD_OP_MSB:`CMD_OP_LSB])
                        3'h1, 3'h2: state_next = flash_host_pkg::S_CYC;
                        3'h3:
                        begin
                            abort_next = !ready_busy_out;
                            rst_n_next = 1'b0;
                            state_next = flash_host_pkg::S_RST_LO;
                        end
                        3'h4:
                        begin
                            first_next = 1'b1;
                            state_next = flash_host_pkg::S_POLL_WAIT;
                        end
                        default: state_next = flash_host_pkg::S_IDLE;
                    endcase
                end
            end
            flash_host_pkg::S_CYC:
                if (cyc.done)
                begin
                    if (!cyc.write)
                        rdata_next = cyc.rdata;
                    finish     = 1'b1;
                    state_next = flash_host_pkg::S_IDLE;
                end
            // reset low for the least pulse
            flash_host_pkg::S_RST_LO:
                if (cnt_reg == RP_CYC - 10'h001)
                begin
                    rst_n_next = 1'b1;
                    cnt_next   = 10'h000;
                    state_next = flash_host_pkg::S_RST_WAIT;
                end
            flash_host_pkg::S_RST_WAIT:
                if (cnt_reg >= (abort_reg ? ABORT_CYC : RH_CYC) - 10'h001)
                begin
                    finish     = 1'b1;
                    state_next = flash_host_pkg::S_IDLE;
                end
            // wait for busy or the busy delay
            flash_host_pkg::S_POLL_WAIT:
                if (!ready_busy_out || cnt_reg == BUSY_CYC - 10'h001)
                    state_next = flash_host_pkg::S_POLL_RD;
            flash_host_pkg::S_POLL_RD:
                if (cyc.done)
                begin
                    rdata_next = cyc.rdata;
                    state_next = flash_host_pkg::S_POLL_CHK;
                end
            flash_host_pkg::S_POLL_CHK:
            begin
                first_next = 1'b0;
                state_next = flash_host_pkg::S_POLL_RD;
                if (cmd_reg[`CMD_TOGGLE_BIT])
                begin
                    if (!first_reg && rdata_reg[`TOGGLE_STATUS_BIT] ==
                        wdata_reg[`TOGGLE_STATUS_BIT])
                        state_next = flash_host_pkg::S_IDLE;
                    wdata_next[`TOGGLE_STATUS_BIT] =
                        rdata_reg[`TOGGLE_STATUS_BIT];
                end
                // poll bit matches expected when finished
                else if (rdata_reg[`POLL_STATUS_BIT] ==
                         wdata_reg[`POLL_STATUS_BIT])
                    state_next = flash_host_pkg::S_IDLE;
                finish = (state_next == flash_host_pkg::S_IDLE);
            end
        endcase
        // set wins over a clear in the same cycle
        done_next = finish || (done_reg && !(wr_en &&
                    paddr == `OFS_STATUS && pwdata[`STS_DONE_BIT]));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= flash_host_pkg::S_IDLE;
            cmd_reg   <= `CMD_RST;
            addr_reg  <= `ADDR_RST;
            wdata_reg <= `WDATA_RST;
            rdata_reg <= `RDATA_RST;
            cnt_reg   <= 10'h000;
            done_reg  <= 1'b0;
            abort_reg <= 1'b0;
            first_reg <= 1'b0;
            rst_n_reg <= 1'b1;
            prdata    <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            cnt_reg   <= cnt_next;
            done_reg  <= done_next;
            abort_reg <= abort_next;
            first_reg <= first_next;
            rst_n_reg <= rst_n_next;
            prdata    <= prdata_next;
        end
    end

    assign flash_reset_n = rst_n_reg;

    flash_bus_cycle u_cycle (
        .pclk         (pclk),
        .presetn      (presetn),
        .cyc          (cyc.slave),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in),
        .flash_ce_n   (flash_ce_n),
        .flash_oe_n   (flash_oe_n),
        .flash_we_n   (flash_we_n)
    );

    // ======================================================================
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rst_low_s;
        !flash_reset_n [*5];
    endsequence
    sequence rst_high_s;
        flash_reset_n && flash_oe_n;
    endsequence

    reset_pulse_a: assert property (
        $fell(flash_reset_n) |-> rst_low_s ##1 flash_reset_n)
        else $error("flash reset pulse width wrong");
    reset_high_a: assert property (
        $rose(flash_reset_n) |-> rst_high_s ##1 rst_high_s)
        else $error("read started too soon after reset");
    poll_start_a: assert property (
        $rose(state_reg == flash_host_pkg::S_POLL_RD) && first_reg
            |-> $past(ready_busy_out) == 1'b0 ||
                $past(cnt_reg) == BUSY_CYC - 10'h001)
        else $error("polling started before algorithm began");
endmodule

// ==== logic/flash_host_regs.svh ====
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// ==========================================================================
// clock and cycle conversion
`define CLK_MHZ                 10
`define CYC_UP(ns)              ((((ns) * `CLK_MHZ) + 999) / 1000)

// ==========================================================================
// register offsets (byte addresses)
`define OFS_CMD                 12'h000
`define OFS_ADDR                12'h004
`define OFS_WDATA               12'h008
`define OFS_RDATA               12'h00C
`define OFS_STATUS              12'h010

// ==========================================================================
// field positions
`define CMD_OP_LSB              0
`define CMD_OP_MSB              2
`define CMD_CE_BIT              3
`define CMD_PROT_BIT            4
`define CMD_TOGGLE_BIT          5
`define STS_ACTIVE_BIT          0
`define STS_READY_BIT           1
`define STS_DONE_BIT            2
`define POLL_STATUS_BIT         7
`define TOGGLE_STATUS_BIT       6

// ==========================================================================
// reset values
`define CMD_RST                 6'h00
`define ADDR_RST                18'h00000
`define WDATA_RST               16'h0000
`define RDATA_RST               16'h0000

// ==========================================================================
// timing in ns, and derived cycle counts
`define RESET_PULSE_MIN_NS      500
`define RESET_HIGH_NS           50
`define ABORT_RECOVERY_TIME_NS  20000
`define BUSY_DELAY_NS           90000
`define WRITE_PULSE_NS          35
`define CS_PULSE_NS             35
`define PROT_PULSE_NS           100
`define READ_ACCESS_NS          90
`define RESET_PULSE_MIN_CYC     `CYC_UP(`RESET_PULSE_MIN_NS)
`define RESET_HIGH_CYC          `CYC_UP(`RESET_HIGH_NS)
`define ABORT_RECOVERY_CYC      `CYC_UP(`ABORT_RECOVERY_TIME_NS)
`define BUSY_DELAY_CYC          `CYC_UP(`BUSY_DELAY_NS)
`define WRITE_PULSE_CYC         `CYC_UP(`WRITE_PULSE_NS)
`define CS_PULSE_CYC            `CYC_UP(`CS_PULSE_NS)
`define PROT_PULSE_CYC          `CYC_UP(`PROT_PULSE_NS)
`define READ_ACCESS_CYC         `CYC_UP(`READ_ACCESS_NS)

`endif

// ==== logic/flash_host_pkg.sv ====
package flash_host_pkg;

    // ======================================================================
    // operations
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_WRITE = 3'h1,
        OP_READ  = 3'h2,
        OP_RESET = 3'h3,
        OP_POLL  = 3'h4
    } op_t;

    // ======================================================================
    // sequencer states
    typedef enum logic [6:0] {
        S_IDLE      = 7'h01,
        S_CYC       = 7'h02,
        S_RST_LO    = 7'h04,
        S_RST_WAIT  = 7'h08,
        S_POLL_WAIT = 7'h10,
        S_POLL_RD   = 7'h20,
        S_POLL_CHK  = 7'h40
    } seq_state_t;

    // ======================================================================
    // bus cycle states
    typedef enum logic [3:0] {
        C_IDLE   = 4'h1,
        C_SETUP  = 4'h2,
        C_STROBE = 4'h4,
        C_HOLD   = 4'h8
    } cyc_state_t;

endpackage

// ==== logic/flash_cyc_if.sv ====
`timescale 1ns/1ns
interface flash_cyc_if;
    logic        req;
    logic        write;
    logic        ce_strobe;
    logic        long_pulse;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;

    modport master (
        output req, write, ce_strobe, long_pulse, addr, wdata,
        input  done, rdata
    );
    modport slave (
        input  req, write, ce_strobe, long_pulse, addr, wdata,
        output done, rdata
    );
endinterface

// ==== logic/flash_bus_cycle.sv ====
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_bus_cycle (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request side
    flash_cyc_if.slave       cyc,
    // flash pins
    output logic [17:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n
);
    localparam logic [3:0] WP_CYC   = 4'(`WRITE_PULSE_CYC);
    localparam logic [3:0] CP_CYC   = 4'(`CS_PULSE_CYC);
    localparam logic [3:0] PROT_CYC = 4'(`PROT_PULSE_CYC);
    localparam logic [3:0] RD_CYC   = 4'(`READ_ACCESS_CYC);

    flash_host_pkg::cyc_state_t state_reg;
    flash_host_pkg::cyc_state_t state_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [3:0]  len;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        ce_n_next;
    logic        oe_n_next;
    logic        we_n_next;
    logic        oe_next;
    logic [17:0] addr_next;
    logic [15:0] dq_next;

    // ======================================================================
    // strobe length and next state
    always_comb
    begin
        if (cyc.write && cyc.long_pulse)
            len = PROT_CYC;
        else if (cyc.write && cyc.ce_strobe)
            len = CP_CYC;
        else if (cyc.write)
            len = WP_CYC;
        else
            len = RD_CYC;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rdata_next = rdata_reg;
        ce_n_next  = 1'b1;
        oe_n_next  = 1'b1;
        we_n_next  = 1'b1;
        oe_next    = flash_dq_oe;
        addr_next  = flash_addr;
        dq_next    = flash_dq_out;
        unique case (state_reg)
            flash_host_pkg::C_IDLE:
            begin
                oe_next = 1'b0;
                if (cyc.req)
                begin
                    state_next = flash_host_pkg::C_SETUP;
                    addr_next  = cyc.addr;
                    dq_next    = cyc.wdata;
                    oe_next    = cyc.write;
                    ce_n_next  = cyc.write && cyc.ce_strobe;
                    we_n_next  = !(cyc.write && cyc.ce_strobe);
                end
            end
            flash_host_pkg::C_SETUP:
            begin
                state_next = flash_host_pkg::C_STROBE;
                cnt_next   = 4'h0;
                ce_n_next  = 1'b0;
                oe_n_next  = cyc.write;
                we_n_next  = !cyc.write;
            end
            flash_host_pkg::C_STROBE:
            begin
                ce_n_next = 1'b0;
                oe_n_next = cyc.write;
                we_n_next = !cyc.write;
                cnt_next  = cnt_reg + 4'h1;
                if (cnt_reg >= len - 4'h1)
                begin
                    state_next = flash_host_pkg::C_HOLD;
                    ce_n_next  = 1'b1;
                    oe_n_next  = 1'b1;
                    we_n_next  = 1'b1;
                    if (!cyc.write)
                        rdata_next = flash_dq_in;
                end
            end
            flash_host_pkg::C_HOLD:
                state_next = flash_host_pkg::C_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= flash_host_pkg::C_IDLE;
            cnt_reg      <= 4'h0;
            rdata_reg    <= `RDATA_RST;
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_dq_oe  <= 1'b0;
            flash_addr   <= `ADDR_RST;
            flash_dq_out <= `WDATA_RST;
        end
        else
        begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            rdata_reg    <= rdata_next;
            flash_ce_n   <= ce_n_next;
            flash_oe_n   <= oe_n_next;
            flash_we_n   <= we_n_next;
            flash_dq_oe  <= oe_next;
            flash_addr   <= addr_next;
            flash_dq_out <= dq_next;
        end
    end

    assign cyc.done  = (state_reg == flash_host_pkg::C_HOLD);
    assign cyc.rdata = rdata_reg;

    // ======================================================================
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ce_pulse_a: assert property (
        $fell(flash_ce_n) && !flash_we_n |-> ##[1:4] flash_ce_n)
        else $error("chip-select write pulse not released");
    prot_pulse_a: assert property (
        $fell(flash_we_n) && cyc.long_pulse
            |-> !flash_we_n ##1 ##[0:3] flash_we_n)
        else $error("protect write pulse too short or stuck");
endmodule

// ==== dv/flash_dev_model.sv ====
`timescale 1ns/1ns
module flash_dev_model #(
    parameter int PROG_NS  = 9000,
    parameter int ERASE_NS = 200000,
    parameter int BUSY_NS  = 500,
    parameter int ABORT_NS = 3000
) (
    // flash pins
    input  wire logic [15:0] dq,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        reset_n,
    output logic [15:0]      dq_in,
    output logic             rb,
    // host timing faults seen
    output int               viol
);
    logic [15:0] mem  = 16'hFFFF;
    logic [15:0] last = 16'h0000;
    logic        alg  = 1'b0;
    logic        ers  = 1'b0;
    logic        tog  = 1'b0;
    int          gen  = 0;
    time         t_wr = 0;
    time         t_lo = 0;
    time         t_up = 0;
    wire         wr   = ~ce_n & ~we_n;
    wire         rd   = ~ce_n & ~oe_n;
    wire  [15:0] val  = alg ? {mem[15:8], ~ers & ~mem[7], tog, mem[5:0]} : mem;

    initial
    begin
        rb   = 1'b1;
        viol = 0;
    end

    // ======================================================================
    // write strobe and algorithm
    always @(posedge wr) t_wr = $time;
    always @(negedge wr)
    begin
        if (t_wr > 0 && $time - t_wr < 100)
            viol++;
        if (reset_n === 1'b1 && !alg && t_wr > 0)
        begin
            mem = dq;
            ers = (dq == 16'h0030);
            alg = 1'b1;
            gen++;
            fork
                run(gen);
            join_none
        end
    end

    task automatic run(input int g);
        #(BUSY_NS);
        if (g == gen)
            rb = 1'b0;
        #((ers ? ERASE_NS : PROG_NS) - BUSY_NS);
        if (g == gen)
        begin
            alg = 1'b0;
            rb  = 1'b1;
            if (ers)
                mem = 16'hFFFF;
        end
    endtask

    // ======================================================================
    // hardware reset
    // abort, ready again
    always @(negedge reset_n)
    begin
        t_lo = $time;
        gen++;
        if (alg)
            rb <= #(ABORT_NS) 1'b1;
        alg = 1'b0;
    end
    always @(posedge reset_n)
    begin
        if (t_lo > 0 && $time - t_lo < 500)
            viol++;
        t_up = $time;
    end

    // ======================================================================
    // reads, released bus shows inverse
    // toggle per read, recovery
    always @(posedge rd)
    begin
        tog = ~tog;
        if (t_up > 0 && $time - t_up < 50)
            viol++;
    end
    always @(negedge rd) last = val;
    assign dq_in = rd ? val : ~last;
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module tb_top;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [17:0] fa;
    logic [15:0] fdo;
    logic        foe;
    logic [15:0] fdi;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        frst_n;
    logic        rb;
    int          viol;
    logic [31:0] rdat;
    logic        err;
    int          miscompares = 0;
    int          n_tests     = 0;

    flash_host u_flash_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_oe(foe),
        .flash_dq_in(fdi), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_reset_n(frst_n), .ready_busy_out(rb));
    flash_dev_model u_flash_dev_model (.dq(fdo & {16{foe}}), .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n), .reset_n(frst_n), .dq_in(fdi), .rb(rb), .viol(viol));

    // ======================================================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task cmd(input logic [31:0] c);
        int k;
        apb(1'b1, `OFS_CMD, c);
        k    = 0;
        rdat = 32'h0;
        while (rdat[`STS_DONE_BIT] !== 1'b1 && k < 3000)
        begin
            apb(1'b0, `OFS_STATUS, 32'h0);
            k++;
        end
        chk(32'(rdat[`STS_DONE_BIT]), 32'h1, "operation never done");
        apb(1'b1, `OFS_STATUS, 32'h4);
    endtask

    task setup(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, `OFS_ADDR, a);
        apb(1'b1, `OFS_WDATA, d);
    endtask

    // ======================================================================
    // scenarios
    task t_reset;
        chk(32'({ce_n, oe_n, we_n, frst_n, foe}), 32'h1E, "idle pins");
        apb(1'b0, 12'hFF0, 32'h0);
        chk(32'({err, rdat[0]}), 32'h2, "unmapped read");
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rdat & 32'h7, 32'h2, "idle status");
    endtask

    task t_sys_reset;
        apb(1'b1, `OFS_CMD, 32'h4);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2)
            @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({ce_n, oe_n, we_n, frst_n, foe}), 32'h1E, "pins after reset");
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rdat & 32'h7, 32'h2, "status after reset");
    endtask

    task t_prog(input logic ce, input logic tm, input logic [31:0] d);
        setup(32'h00123, d);
        cmd(ce ? 32'h9 : 32'h1);
        cmd(tm ? 32'h24 : 32'h4);
        chk(32'(rb), 32'h1, "poll ended while busy");
        cmd(32'h2);
        apb(1'b0, `OFS_RDATA, 32'h0);
        chk(rdat & 32'hFFFF, d, "programmed data");
        chk(32'(fa), 32'h00123, "program address");
    endtask

    task t_erase;
        setup(32'h2A000, 32'h0030);
        cmd(32'h11);
        apb(1'b1, `OFS_WDATA, 32'h80);
        cmd(32'h4);
        chk(32'(rb), 32'h1, "erase poll ended while busy");
        cmd(32'h2);
        apb(1'b0, `OFS_RDATA, 32'h0);
        chk(rdat & 32'hFFFF, 32'hFFFF, "erased data");
        chk(32'(fa), 32'h2A000, "erase sector address");
    endtask

    task t_abort;
        int k;
        setup(32'h00040, 32'h5555);
        cmd(32'h1);
        k = 0;
        while (rb !== 1'b0 && k < 50)
        begin
            @(posedge pclk);
            k++;
        end
        chk(32'(rb), 32'h0, "no busy");
        cmd(32'h3);
        chk(32'(rb), 32'h1, "still busy after abort");
        cmd(32'h3);
        cmd(32'h2);
        apb(1'b0, `OFS_RDATA, 32'h0);
        chk(rdat & 32'hFFFF, 32'h5555, "read after reset");
    endtask

    // ======================================================================
    // run control
    task stop_test;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever
            #50 pclk = ~pclk;
    end

    initial
    begin
        #6000000;
        miscompares++;
        stop_test;
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (12)
            @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_sys_reset;
        t_prog(1'b0, 1'b0, 32'hA5C3);
        t_prog(1'b1, 1'b1, 32'h3C5A);
        t_prog(1'b0, 1'b1, 32'h0081);
        t_erase;
        t_abort;
        chk(32'(viol), 32'h0, "pin timing");
        stop_test;
    end
endmodule
